// [core/ppim_params.svh]
// Behaviour
// - polarity 1 pulls down, 0 pulls up
// - active CAN ignores pull-down on receive pin
// - wired-or drives 0 low, leaves 1 undriven
// - open-drain select ignored on input pins
// - reserved register reads zero, ignores writes
// - gpio output drives stored data bit
// - data read: register if output, else pin
// - bit 7 is plain gpio with interrupt
// - pwm or shut-down overrides gpio on bit 5
// - bit 5 carries pwm output or shut-down input
// - enabled pwm channel overrides gpio, bits 4-0
// - pin interrupts work in input and output
// - direction 1 output, 0 input
// - polarity 1 rising edge, 0 falling edge
// - per-pin enable masks the pin interrupt
`ifndef PPIM_PARAMS_SVH
`define PPIM_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PPIM_OFS_M_PULL_POL   4'h0
`define PPIM_OFS_M_OPEN_DRAIN 4'h1
`define PPIM_OFS_RSVD         4'h2
`define PPIM_OFS_P_DATA       4'h3
`define PPIM_OFS_P_DIR        4'h4
`define PPIM_OFS_P_EDGE_POL   4'h5
`define PPIM_OFS_P_IRQ_EN     4'h6
`define PPIM_OFS_P_IRQ_FLAG   4'h7

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define PPIM_M_MASK           6'h3F
`define PPIM_P_MASK           8'hBF
`define PPIM_CAN_RX_BIT       0
`define PPIM_ESD_BIT          5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PPIM_RST_M            6'h00
`define PPIM_RST_P            8'h00

`endif

// [core/ppim_pkg.sv]
package ppim_pkg;

   typedef logic [7:0] ppim_byte_t;
   typedef logic [3:0] ppim_addr_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      ppim_addr_t addr;
      ppim_byte_t wdata;
   } ppim_bus_s;

   typedef struct packed {
      logic [5:0] out;
      logic [5:0] oe;
      logic [5:0] pull_en;
      logic [5:0] pull_dn;
   } ppim_m_pad_s;

   typedef struct packed {
      ppim_byte_t out;
      ppim_byte_t oe;
      ppim_byte_t pull_en;
      ppim_byte_t pull_dn;
   } ppim_p_pad_s;

endpackage

// [core/ppim_pin_irq.sv]
`timescale 1ns/1ps
`include "ppim_params.svh"

module ppim_pin_irq (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire ppim_pkg::ppim_byte_t pin,
   input  wire ppim_pkg::ppim_byte_t rise_sel,
   input  wire ppim_pkg::ppim_byte_t clr,
   output      ppim_pkg::ppim_byte_t flag
);

   ppim_pkg::ppim_byte_t prev_q;
   ppim_pkg::ppim_byte_t flag_q;
   ppim_pkg::ppim_byte_t flag_d;

   // ----------------------------------------------------------------------
   // edge capture, set wins over clear
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         always_comb begin
            logic edge_hit;
            edge_hit = rise_sel[g] ? (pin[g] & ~prev_q[g])
                                   : (~pin[g] & prev_q[g]);
            flag_d[g] = edge_hit | (flag_q[g] & ~clr[g]);
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= `PPIM_RST_P;
         flag_q <= `PPIM_RST_P;
      end else begin
         prev_q <= pin & `PPIM_P_MASK;
         flag_q <= flag_d & `PPIM_P_MASK;
      end
   end

   assign flag = flag_q;

endmodule // ppim_pin_irq

// [core/ppim_top.sv]
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "ppim_params.svh"

module ppim_top (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire ppim_pkg::ppim_bus_s  bus,
   output      ppim_pkg::ppim_byte_t rdata,
   input  wire logic [5:0]           m_dir,
   input  wire logic [5:0]           m_pull_en,
   input  wire logic [5:0]           m_data,
   input  wire logic                 can_active,
   output      ppim_pkg::ppim_m_pad_s m_pad,
   input  wire ppim_pkg::ppim_byte_t p_in,
   input  wire ppim_pkg::ppim_byte_t p_pull_en,
   input  wire logic [5:0]           pwm_en,
   input  wire logic [5:0]           pwm_out,
   input  wire logic                 pwm_esd_en,
   output      ppim_pkg::ppim_p_pad_s p_pad,
   output      logic                 pwm_esd_in,
   output      logic                 pin_irq
);

   // ----------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------
   logic [5:0]            m_pol_q,  m_pol_d;
   logic [5:0]            m_od_q,   m_od_d;
   ppim_pkg::ppim_byte_t  p_data_q, p_data_d;
   ppim_pkg::ppim_byte_t  p_dir_q,  p_dir_d;
   ppim_pkg::ppim_byte_t  p_pol_q,  p_pol_d;
   ppim_pkg::ppim_byte_t  p_ie_q,   p_ie_d;
   ppim_pkg::ppim_byte_t  rdata_q,  rdata_d;
   ppim_pkg::ppim_byte_t  flag_clr;
   ppim_pkg::ppim_byte_t  p_flag;

   always_comb begin
      m_pol_d  = m_pol_q;
      m_od_d   = m_od_q;
      p_data_d = p_data_q;
      p_dir_d  = p_dir_q;
      p_pol_d  = p_pol_q;
      p_ie_d   = p_ie_q;
      flag_clr = `PPIM_RST_P;
      if (bus.wr) begin
         case (bus.addr)
            `PPIM_OFS_M_PULL_POL:   m_pol_d  = bus.wdata[5:0];
            `PPIM_OFS_M_OPEN_DRAIN: m_od_d   = bus.wdata[5:0];
            `PPIM_OFS_P_DATA:       p_data_d = bus.wdata & `PPIM_P_MASK;
            `PPIM_OFS_P_DIR:        p_dir_d  = bus.wdata & `PPIM_P_MASK;
            `PPIM_OFS_P_EDGE_POL:   p_pol_d  = bus.wdata & `PPIM_P_MASK;
            `PPIM_OFS_P_IRQ_EN:     p_ie_d   = bus.wdata & `PPIM_P_MASK;
            `PPIM_OFS_P_IRQ_FLAG:   flag_clr = bus.wdata & `PPIM_P_MASK;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // read path, data valid only the cycle after the strobe
   // ----------------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            `PPIM_OFS_M_PULL_POL:   rdata_d = {2'h0, m_pol_q};
            `PPIM_OFS_M_OPEN_DRAIN: rdata_d = {2'h0, m_od_q};
            `PPIM_OFS_RSVD:         rdata_d = 8'h00;
            `PPIM_OFS_P_DATA:       rdata_d = ((p_data_q & p_dir_q)
                                             | (p_in & ~p_dir_q))
                                             & `PPIM_P_MASK;
            `PPIM_OFS_P_DIR:        rdata_d = p_dir_q;
            `PPIM_OFS_P_EDGE_POL:   rdata_d = p_pol_q;
            `PPIM_OFS_P_IRQ_EN:     rdata_d = p_ie_q;
            `PPIM_OFS_P_IRQ_FLAG:   rdata_d = p_flag;
            default:                rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         m_pol_q  <= `PPIM_RST_M;
         m_od_q   <= `PPIM_RST_M;
         p_data_q <= `PPIM_RST_P;
         p_dir_q  <= `PPIM_RST_P;
         p_pol_q  <= `PPIM_RST_P;
         p_ie_q   <= `PPIM_RST_P;
         rdata_q  <= `PPIM_RST_P;
      end else begin
         m_pol_q  <= m_pol_d;
         m_od_q   <= m_od_d;
         p_data_q <= p_data_d;
         p_dir_q  <= p_dir_d;
         p_pol_q  <= p_pol_d;
         p_ie_q   <= p_ie_d;
         rdata_q  <= rdata_d;
      end
   end

   assign rdata = rdata_q;

   // ----------------------------------------------------------------------
   // port m pads
   // ----------------------------------------------------------------------
   ppim_pkg::ppim_m_pad_s m_pad_q, m_pad_d;

   genvar gm;
   generate
      for (gm = 0; gm < 6; gm++) begin : g_m
         always_comb begin
            logic drv_low;
            drv_low = m_od_q[gm];
            // wired-or drives only a low level
            m_pad_d.out[gm]     = drv_low ? 1'b0 : m_data[gm];
            m_pad_d.oe[gm]      = m_dir[gm] & (~drv_low | ~m_data[gm]);
            m_pad_d.pull_en[gm] = m_pull_en[gm] & (~m_dir[gm] | drv_low);
            m_pad_d.pull_dn[gm] = m_pull_en[gm] & (~m_dir[gm] | drv_low)
                                & m_pol_q[gm];
            if (gm == `PPIM_CAN_RX_BIT && can_active) begin
               m_pad_d.pull_dn[gm] = 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // port p pads
   // ----------------------------------------------------------------------
   ppim_pkg::ppim_p_pad_s p_pad_q, p_pad_d;
   logic                  esd_in_q, esd_in_d;

   genvar gp;
   generate
      for (gp = 0; gp < 8; gp++) begin : g_p
         always_comb begin
            logic pwm_drive;
            logic pwm_input;
            pwm_drive = 1'b0;
            pwm_input = 1'b0;
            if (gp < 6) begin
               pwm_drive = pwm_en[gp % 6];
               if (gp == `PPIM_ESD_BIT) begin
                  pwm_input = pwm_esd_en;
                  pwm_drive = pwm_en[gp % 6] & ~pwm_esd_en;
               end
            end
            if (gp == 6) begin
               p_pad_d.out[gp] = 1'b0;
               p_pad_d.oe[gp]  = 1'b0;
            end else if (pwm_input) begin
               p_pad_d.out[gp] = 1'b0;
               p_pad_d.oe[gp]  = 1'b0;
            end else if (pwm_drive) begin
               p_pad_d.out[gp] = pwm_out[gp % 6];
               p_pad_d.oe[gp]  = 1'b1;
            end else begin
               p_pad_d.out[gp] = p_data_q[gp];
               p_pad_d.oe[gp]  = p_dir_q[gp];
            end
            p_pad_d.pull_en[gp] = (gp == 6) ? 1'b0
                                : (p_pull_en[gp] & ~p_pad_d.oe[gp]);
            p_pad_d.pull_dn[gp] = p_pad_d.pull_en[gp] & p_pol_q[gp];
         end
      end
   endgenerate

   assign esd_in_d = pwm_esd_en & p_in[`PPIM_ESD_BIT];

   // ----------------------------------------------------------------------
   // pin interrupts
   // ----------------------------------------------------------------------
   logic irq_q, irq_d;

   ppim_pin_irq u_pin_irq (
      .clk      (clk),
      .rst_n    (rst_n),
      .pin      (p_in & `PPIM_P_MASK),
      .rise_sel (p_pol_q),
      .clr      (flag_clr),
      .flag     (p_flag)
   );

   assign irq_d = |(p_flag & p_ie_q);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         m_pad_q  <= '0;
         p_pad_q  <= '0;
         esd_in_q <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         m_pad_q  <= m_pad_d;
         p_pad_q  <= p_pad_d;
         esd_in_q <= esd_in_d;
         irq_q    <= irq_d;
      end
   end

   assign m_pad      = m_pad_q;
   assign p_pad      = p_pad_q;
   assign pwm_esd_in = esd_in_q;
   assign pin_irq    = irq_q;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_M_PULL_POL: assert property (
      ((m_pad.pull_dn & ~m_pad.pull_en) == 6'h00)
      && ($past(m_pol_q & m_pull_en & ~m_dir & 6'h3E) == (m_pad.pull_dn & ~$past(m_dir) & 6'h3E)))
      else $error("pull-down does not follow polarity");

   AST_CAN_PULL: assert property (
      can_active |=> !m_pad.pull_dn[0])
      else $error("pull-down on can receive while can active");

   AST_OD_DRIVE: assert property (
      (m_od_q[1] && m_dir[1] && m_data[1]) |=> !m_pad.oe[1] ##0 !m_pad.out[1])
      else $error("wired-or high level driven");

   AST_IN_UNDRIVEN: assert property (
      (m_pad.oe & ~$past(m_dir)) == 6'h00)
      else $error("input pin driven on port m");

   AST_RSVD_READ: assert property (
      (bus.rd && bus.addr == `PPIM_OFS_RSVD) |=> rdata == 8'h00)
      else $error("reserved register read not zero");

   AST_P_READ: assert property (
      (bus.rd && bus.addr == `PPIM_OFS_P_DATA)
      |=> rdata == ($past((p_data_q & p_dir_q) | (p_in & ~p_dir_q)) & 8'hBF))
      else $error("port p data read source wrong");

   AST_BIT7_GPIO: assert property (
      p_dir_q[7] |=> p_pad.oe[7] && p_pad.out[7] == $past(p_data_q[7]))
      else $error("bit 7 not driven from data register");

   AST_ESD_INPUT: assert property (
      (pwm_esd_en && pwm_en[5]) |=> !p_pad.oe[5] ##1 pwm_esd_in == $past(p_in[5]) || !$past(pwm_esd_en))
      else $error("shut-down input not taken on bit 5");

   AST_PWM_OVR: assert property (
      pwm_en[0] |=> p_pad.oe[0] && p_pad.out[0] == $past(pwm_out[0]))
      else $error("pwm does not override gpio");

   AST_IRQ_EDGE: assert property (
      (p_pol_q[7] && $rose(p_in[7])) |=> p_flag[7])
      else $error("rising edge not flagged");

   AST_IRQ_OUT: assert property (
      ((p_flag & p_ie_q) != 8'h00) |=> pin_irq ##0 1'b1)
      else $error("enabled flag gives no interrupt");

   AST_GPIO_OUT: assert property (
      (p_dir_q[3] && !pwm_en[3]) |=> p_pad.oe[3] && p_pad.out[3] == $past(p_data_q[3]))
      else $error("gpio output does not drive data bit");

   AST_P_DIR_IN: assert property (
      !p_dir_q[7] |=> !p_pad.oe[7])
      else $error("input pin driven on port p");

   AST_ESD_UNDRIVEN: assert property (
      pwm_esd_en |=> !p_pad.oe[5])
      else $error("shut-down pin driven");

   AST_ESD_LOW: assert property (
      !pwm_esd_en |=> !pwm_esd_in)
      else $error("shut-down input active while disabled");

   AST_PWM_BIT5: assert property (
      (pwm_en[5] && !pwm_esd_en) |=> p_pad.oe[5] && p_pad.out[5] == $past(pwm_out[5]))
      else $error("pwm does not drive bit 5");

   AST_IRQ_FALL: assert property (
      (!p_pol_q[0] && $fell(p_in[0])) |=> p_flag[0])
      else $error("falling edge not flagged");

   AST_IRQ_MASK: assert property (
      ((p_flag & p_ie_q) == 8'h00) |=> !pin_irq)
      else $error("masked flag gives interrupt");

   AST_FLAG_CLEAR: assert property (
      (bus.wr && bus.addr == `PPIM_OFS_P_IRQ_FLAG && bus.wdata[7] && p_pol_q[7] && !p_in[7])
      |=> !p_flag[7])
      else $error("flag not cleared by write");

   AST_PP_DRIVE: assert property (
      (!m_od_q[3] && m_dir[3]) |=> m_pad.oe[3] && m_pad.out[3] == $past(m_data[3]))
      else $error("push-pull output not driven");

   AST_REG_WRITE: assert property (
      (bus.wr && bus.addr == `PPIM_OFS_P_DIR) |=> p_dir_q == ($past(bus.wdata) & 8'hBF))
      else $error("direction write not stored");

   AST_BIT6_IDLE: assert property (
      !p_pad.oe[6] && !p_pad.pull_en[6])
      else $error("unimplemented bit 6 active");

   COV_PWM_OVR:  cover property (!p_dir_q[0] ##1 pwm_en[0] ##1 p_pad.oe[0]);
   COV_ESD:      cover property (pwm_esd_en ##2 pwm_esd_in);
   COV_IRQ:      cover property ($rose(p_in[7]) ##1 p_flag[7] ##1 pin_irq);
   COV_OD_LOW:   cover property (m_od_q[2] && m_dir[2] && !m_data[2] ##1 m_pad.oe[2]);
   COV_FLAG_CLR: cover property (p_flag[7] ##1 !p_flag[7]);

endmodule // ppim_top

// [verification/ppim_pins.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// port p pin model: pad drive, outside driver, pull or drifting float
// ----------------------------------------------------------------------
module ppim_pins (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire ppim_pkg::ppim_p_pad_s p_pad,
   input  wire ppim_pkg::ppim_byte_t  ext_val,
   input  wire ppim_pkg::ppim_byte_t  ext_oe,
   output      ppim_pkg::ppim_byte_t  p_in
);
   ppim_pkg::ppim_byte_t last_q;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (p_pad.oe[i]) begin
            p_in[i] = p_pad.out[i];
         end else if (ext_oe[i]) begin
            p_in[i] = ext_val[i];
         end else if (p_pad.pull_en[i]) begin
            p_in[i] = ~p_pad.pull_dn[i];
         end else begin
            p_in[i] = ~last_q[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_q <= 8'h00;
      end else begin
         last_q <= p_in;
      end
   end
endmodule // ppim_pins

// [verification/test_ppim_top.sv]
`timescale 1ns/1ps

module test_ppim_top;
   logic                  clk;
   logic                  rst_n;
   ppim_pkg::ppim_bus_s   bus;
   ppim_pkg::ppim_byte_t  rdata, got, exp, p_in, p_pull_en, ext_val, ext_oe;
   logic [5:0]            m_dir, m_pull_en, m_data, pwm_en, pwm_out;
   logic                  can_active, pwm_esd_en, pwm_esd_in, pin_irq;
   ppim_pkg::ppim_m_pad_s m_pad;
   ppim_pkg::ppim_p_pad_s p_pad;
   int                    fail_count;
   int                    checks;

   ppim_top dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .m_dir(m_dir),
      .m_pull_en(m_pull_en), .m_data(m_data), .can_active(can_active), .m_pad(m_pad),
      .p_in(p_in), .p_pull_en(p_pull_en), .pwm_en(pwm_en), .pwm_out(pwm_out),
      .pwm_esd_en(pwm_esd_en), .p_pad(p_pad), .pwm_esd_in(pwm_esd_in), .pin_irq(pin_irq));

   ppim_pins pins_u (.clk(clk), .rst_n(rst_n), .p_pad(p_pad), .ext_val(ext_val),
      .ext_oe(ext_oe), .p_in(p_in));

   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input ppim_pkg::ppim_byte_t seen, input ppim_pkg::ppim_byte_t want);
      checks++;
      if (seen !== want) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic wr_reg(input ppim_pkg::ppim_addr_t a, input ppim_pkg::ppim_byte_t d);
      @(posedge clk) bus <= {1'h1, 1'h0, a, d};
      @(posedge clk) bus <= '0;
   endtask

   task automatic rd_reg(input ppim_pkg::ppim_addr_t a, output ppim_pkg::ppim_byte_t d);
      @(posedge clk) bus <= {1'h0, 1'h1, a, 8'h00};
      @(posedge clk) bus <= '0;
      @(posedge clk) d = rdata;
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
   endtask

   task automatic wait_irq();
      for (int i = 0; i < 10 && pin_irq !== 1'h1; i++) begin
         @(posedge clk);
      end
      chk({7'h00, pin_irq}, 8'h01);
      if (pin_irq !== 1'h1) begin
         give_verdict();
      end
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      fail_count = 0;
      checks = 0;
      bus = '0;
      {m_dir, m_pull_en, m_data, pwm_en, pwm_out} = '0;
      {can_active, pwm_esd_en} = 2'h0;
      p_pull_en = 8'h00;
      ext_val = 8'h00;
      ext_oe = 8'hFF;
      rst_n = 1'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      for (int i = 0; i < 9; i++) begin
         rd_reg(i[3:0], got);
         chk(got, 8'h00);
      end
      for (int i = 0; i < 10; i++) begin
         if (i != 3 && i != 7 && i != 8) begin
            exp = (i < 2) ? 8'h3F : ((i > 3 && i < 7) ? 8'hBF : 8'h00);
            wr_reg(i[3:0], 8'hFF);
            rd_reg(i[3:0], got);
            chk(got, exp);
            wr_reg(i[3:0], 8'h00);
         end
      end
      // port m pulls and wired-or
      wr_reg(4'h0, 8'h15);
      m_pull_en <= 6'h3F;
      settle();
      chk({2'h0, m_pad.pull_dn}, 8'h15);
      chk({2'h0, m_pad.pull_en}, 8'h3F);
      can_active <= 1'h1;
      settle();
      chk({2'h0, m_pad.pull_dn}, 8'h14);
      can_active <= 1'h0;
      wr_reg(4'h1, 8'h3F);
      m_dir <= 6'h3F;
      m_data <= 6'h2A;
      settle();
      chk({2'h0, m_pad.oe}, 8'h15);
      chk({2'h0, m_pad.out & m_pad.oe}, 8'h00);
      wr_reg(4'h1, 8'h00);
      settle();
      chk({2'h0, m_pad.oe}, 8'h3F);
      chk({2'h0, m_pad.out}, 8'h2A);
      wr_reg(4'h1, 8'h3F);
      m_dir <= 6'h00;
      settle();
      chk({2'h0, m_pad.oe}, 8'h00);
      // port p gpio
      wr_reg(4'h4, 8'hBF);
      wr_reg(4'h3, 8'hA5);
      settle();
      chk(p_pad.oe, 8'hBF);
      chk(p_pad.out, 8'hA5);
      rd_reg(4'h3, got);
      chk(got, 8'hA5);
      wr_reg(4'h4, 8'h00);
      ext_val <= 8'h5A;
      settle();
      rd_reg(4'h3, got);
      chk(got, 8'h1A);
      chk(p_pad.oe, 8'h00);
      p_pull_en <= 8'hFF;
      wr_reg(4'h5, 8'h0F);
      settle();
      chk(p_pad.pull_en, 8'hBF);
      chk(p_pad.pull_dn, 8'h0F);
      p_pull_en <= 8'h00;
      wr_reg(4'h5, 8'h00);
      // pwm overrides
      pwm_en <= 6'h1F;
      pwm_out <= 6'h0A;
      wr_reg(4'h3, 8'hFF);
      settle();
      chk(p_pad.oe, 8'h1F);
      chk(p_pad.out & 8'h1F, 8'h0A);
      pwm_en <= 6'h3F;
      pwm_out <= 6'h2A;
      settle();
      chk(p_pad.oe, 8'h3F);
      chk(p_pad.out & 8'h3F, 8'h2A);
      pwm_esd_en <= 1'h1;
      ext_val <= 8'h20;
      settle();
      chk(p_pad.oe, 8'h1F);
      chk({7'h00, pwm_esd_in}, 8'h01);
      ext_val <= 8'h00;
      settle();
      chk({7'h00, pwm_esd_in}, 8'h00);
      pwm_en <= 6'h00;
      pwm_esd_en <= 1'h0;
      ext_val <= 8'h01;
      settle();
      // pin interrupts
      wr_reg(4'h7, 8'hFF);
      wr_reg(4'h5, 8'h81);
      wr_reg(4'h6, 8'h81);
      ext_val <= 8'h00;
      settle();
      rd_reg(4'h7, got);
      chk(got, 8'h00);
      chk({7'h00, pin_irq}, 8'h00);
      ext_val <= 8'h81;
      settle();
      rd_reg(4'h7, got);
      chk(got, 8'h81);
      chk({7'h00, pin_irq}, 8'h01);
      wr_reg(4'h6, 8'h00);
      settle();
      chk({7'h00, pin_irq}, 8'h00);
      wr_reg(4'h7, 8'h81);
      rd_reg(4'h7, got);
      chk(got, 8'h00);
      wr_reg(4'h6, 8'h80);
      wr_reg(4'h4, 8'h80);
      ext_oe <= 8'h7F;
      wr_reg(4'h3, 8'h00);
      settle();
      wr_reg(4'h7, 8'hFF);
      wr_reg(4'h3, 8'h80);
      wait_irq();
      rd_reg(4'h7, got);
      chk(got, 8'h80);
      give_verdict();
   end
endmodule // test_ppim_top
